// >>> cpc_pkg.sv
`default_nettype none
package cpc_pkg;

  // ==========================================================
  // Modes, states and carriers
  typedef enum logic [2:0] {
    MODE_MASTER,
    MODE_ASYNC_PERIPH,
    MODE_SLAVE,
    MODE_SYNC_PERIPH,
    MODE_MICRO
  } cpc_mode_t;

  typedef enum logic [2:0] {
    ST_CLEAR,
    ST_WAIT,
    ST_LOAD,
    ST_DONE_HOLD,
    ST_USER
  } cpc_state_t;

  typedef struct packed {
    cpc_mode_t mode;
    logic osc_slow;
  } cpc_cfg_t;

  typedef struct packed {
    logic rb_enable;
    logic reset_as_logic;
  } cpc_opt_t;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int CLK_HZ = 40_000_000;
  localparam int OSC_FAST_HZ = 10_000_000;
  localparam int OSC_SLOW_HZ = 1_250_000;
  localparam int OSC_FAST_HALF = CLK_HZ / (2 * OSC_FAST_HZ);
  localparam int OSC_SLOW_HALF = CLK_HZ / (2 * OSC_SLOW_HZ);
  localparam int CLEAR_TIME_NS = 10_000;
  localparam int CLEAR_CYCLES =
    (CLEAR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // Reset values
  localparam cpc_cfg_t CFG_RST = '{mode: MODE_MASTER, osc_slow: 1'b0};
  localparam int RB_START_FRAME = 0;

  function automatic logic cpc_drives_strobe(cpc_mode_t m);
    return (m == MODE_MASTER) || (m == MODE_ASYNC_PERIPH) ||
           (m == MODE_MICRO);
  endfunction : cpc_drives_strobe

endpackage : cpc_pkg
`default_nettype wire

// >>> cpc_config_pin_control.sv
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - While configuring, every user I/O is high impedance with pull-up on.
// - After configuration, unused I/O stays high impedance with pull-up on.
// - Reset pin low during configuration restarts it; pin has pull-up then.
// - After configuration, reset pin may drive logic cell async set/reset.
// - Master and asynchronous peripheral modes drive the strobe pin out.
// - Microprocessor mode uses the strobe internally and drives it out.
// - Completion pin held low externally delays start-up until released.
// - Open-drain completion pin released high only once loading completes.
// - Low reprogram input restarts configuration and resets boundary scan.
// - During loading and completion hold, low readback trigger forces global tristate.
// - After configuration, option picks tristate or falling-edge readback.
// - Shared output carries readback data or boundary-scan test data.
// - Mode selects are captured on the wait pin rising edge.
// - Speed select captured on wait rise: low 10 MHz, high 1.25 MHz.
// - Mode pins pulled up while configuring, never user I/O; speed pin becomes user I/O.
// - One option group acts at completion release, one at I/O release.
// - Wait pin held low while clearing; held low externally, device waits.
// - Busy-high flag high and busy-low flag low until configured.
module cpc_config_pin_control #(
  parameter int N_IO = 8,
  parameter int FRAME_W = 16,
  parameter cpc_pkg::cpc_mode_t MODE_TABLE [8] = '{
    cpc_pkg::MODE_MASTER, cpc_pkg::MODE_MASTER,
    cpc_pkg::MODE_ASYNC_PERIPH, cpc_pkg::MODE_SYNC_PERIPH,
    cpc_pkg::MODE_SLAVE, cpc_pkg::MODE_SLAVE,
    cpc_pkg::MODE_MICRO, cpc_pkg::MODE_SLAVE}
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Configuration pins
  input wire logic reset_pin_n,
  input wire logic reprogram_n,
  input wire logic [2:0] cfg_mode_sel,
  input wire logic osc_speed_sel,
  input wire logic rd_trig_n,
  input wire logic init_in,
  output logic init_out,
  output logic init_oe,
  input wire logic done_in,
  output logic done_out,
  output logic done_oe,
  input wire logic strobe_in,
  output logic strobe_out,
  output logic strobe_oe,
  input wire logic [7:0] data_in,
  // Shared readback / test data pin
  input wire logic tdo_sel,
  input wire logic jtag_tdo,
  input wire logic rb_serial,
  output logic shared_out,
  // Options and user I/O
  input wire cpc_pkg::cpc_opt_t opt,
  input wire logic load_complete,
  input wire logic [N_IO-1:0] io_used,
  output logic [N_IO-1:0] io_enable,
  output logic [N_IO-1:0] io_pullup,
  // Configuration byte stream
  output logic [7:0] byte_data,
  output logic byte_valid,
  input wire logic byte_ready,
  output logic overflow,
  // Status
  output cpc_pkg::cpc_cfg_t cfg,
  output logic cfg_busy_high_flag,
  output logic cfg_busy_low_flag,
  output logic mode_pullup_en,
  output logic osc_user_io,
  output logic logic_reset,
  output logic jtag_reset,
  output logic global_tristate,
  output logic readback_start,
  output logic [FRAME_W-1:0] readback_frame,
  output logic done_group_apply,
  output logic io_group_apply
);

  // ==========================================================
  // Pin synchronisers
  localparam int SYNC_W = 18;
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic reset_s, reprog_s, init_s, done_s, strobe_s, rdtrig_s, osc_s;
  logic [2:0] mode_s;
  logic [7:0] data_s;

  always_ff @(posedge clk_sys) begin
    sync1_q <= {reset_pin_n, reprogram_n, init_in, done_in, strobe_in,
                rd_trig_n, osc_speed_sel, cfg_mode_sel, data_in};
    sync2_q <= sync1_q;
  end

  assign {reset_s, reprog_s, init_s, done_s, strobe_s, rdtrig_s, osc_s,
          mode_s, data_s} = sync2_q;

  logic init_prev_q, strobe_prev_q, rdtrig_prev_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_n)
    begin
      init_prev_q <= 1'b0;
      strobe_prev_q <= 1'b0;
      rdtrig_prev_q <= 1'b1;
    end else
    begin
      init_prev_q <= init_s;
      strobe_prev_q <= strobe_s;
      rdtrig_prev_q <= rdtrig_s;
    end
  end

  // ==========================================================
  // Start-up sequence
  localparam int CLR_W = $clog2(cpc_pkg::CLEAR_CYCLES + 1);
  cpc_pkg::cpc_state_t state_q;
  logic [CLR_W-1:0] clr_cnt_q;
  logic in_cfg;
  logic init_rise;

  assign in_cfg = (state_q != cpc_pkg::ST_USER);
  assign init_rise = init_s && !init_prev_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_n || !reprog_s)
    begin
      state_q <= cpc_pkg::ST_CLEAR;
      clr_cnt_q <= '0;
    end else if (in_cfg && !reset_s)
    begin
      state_q <= cpc_pkg::ST_CLEAR;
      clr_cnt_q <= '0;
    end else
    begin
      case (state_q)
        cpc_pkg::ST_CLEAR:
        begin
          if (clr_cnt_q == CLR_W'(cpc_pkg::CLEAR_CYCLES - 1))
            state_q <= cpc_pkg::ST_WAIT;
          else
            clr_cnt_q <= clr_cnt_q + 1'b1;
        end
        // External low on the wait pin keeps us here
        cpc_pkg::ST_WAIT:
          if (init_rise)
            state_q <= cpc_pkg::ST_LOAD;
        cpc_pkg::ST_LOAD:
          if (load_complete)
            state_q <= cpc_pkg::ST_DONE_HOLD;
        cpc_pkg::ST_DONE_HOLD:
          if (done_s)
            state_q <= cpc_pkg::ST_USER;
        cpc_pkg::ST_USER:
          state_q <= cpc_pkg::ST_USER;
        default:
          state_q <= cpc_pkg::ST_CLEAR;
      endcase
    end
  end

  // Mode and speed latched once per start-up
  always_ff @(posedge clk_sys) begin
    if (!rst_n)
      cfg <= cpc_pkg::CFG_RST;
    else if (state_q == cpc_pkg::ST_WAIT && init_rise)
    begin
      cfg.mode <= MODE_TABLE[mode_s];
      cfg.osc_slow <= osc_s;
    end
  end

  // ==========================================================
  // Open-drain pins and status
  assign init_out = 1'b0;
  assign done_out = 1'b0;

  always_ff @(posedge clk_sys) begin
    if (!rst_n)
    begin
      init_oe <= 1'b1;
      done_oe <= 1'b1;
      cfg_busy_high_flag <= 1'b1;
      cfg_busy_low_flag <= 1'b0;
      mode_pullup_en <= 1'b1;
      osc_user_io <= 1'b0;
      jtag_reset <= 1'b1;
      done_group_apply <= 1'b0;
      io_group_apply <= 1'b0;
    end else
    begin
      init_oe <= (state_q == cpc_pkg::ST_CLEAR);
      done_oe <= (state_q == cpc_pkg::ST_CLEAR) ||
                 (state_q == cpc_pkg::ST_WAIT) ||
                 (state_q == cpc_pkg::ST_LOAD);
      cfg_busy_high_flag <= in_cfg;
      cfg_busy_low_flag <= !in_cfg;
      mode_pullup_en <= in_cfg;
      osc_user_io <= !in_cfg;
      jtag_reset <= !reprog_s;
      done_group_apply <= (state_q == cpc_pkg::ST_LOAD) &&
                          load_complete;
      io_group_apply <= (state_q == cpc_pkg::ST_DONE_HOLD) && done_s;
    end
  end

  // ==========================================================
  // Tristate, readback and reset routing
  logic gts_d;
  logic rb_fall;

  assign rb_fall = rdtrig_prev_q && !rdtrig_s;

  // Trigger not looked at before loading; source holds it high then
  always_comb begin
    gts_d = 1'b0;
    if (state_q == cpc_pkg::ST_LOAD || state_q == cpc_pkg::ST_DONE_HOLD)
      gts_d = !rdtrig_s;
    else if (state_q == cpc_pkg::ST_USER && !opt.rb_enable)
      gts_d = !rdtrig_s;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n)
    begin
      global_tristate <= 1'b0;
      io_enable <= '0;
      io_pullup <= '1;
      logic_reset <= 1'b0;
      readback_start <= 1'b0;
      readback_frame <= FRAME_W'(cpc_pkg::RB_START_FRAME);
      shared_out <= 1'b0;
    end else
    begin
      global_tristate <= gts_d;
      if (in_cfg)
      begin
        io_enable <= '0;
        io_pullup <= '1;
      end else
      begin
        io_enable <= gts_d ? '0 : io_used;
        io_pullup <= ~io_used;
      end
      logic_reset <= !in_cfg && opt.reset_as_logic && !reset_s;
      readback_start <= !in_cfg && opt.rb_enable && rb_fall;
      if (!in_cfg && opt.rb_enable && rb_fall)
        readback_frame <= FRAME_W'(cpc_pkg::RB_START_FRAME);
      shared_out <= tdo_sel ? jtag_tdo : rb_serial;
    end
  end

  // ==========================================================
  // Configuration strobe
  logic drive_mode;
  logic [4:0] div_q;
  logic [4:0] half;
  logic div_end;
  logic push_req, push;
  logic v0_q, v1_q;
  logic [7:0] d0_q, d1_q;
  logic pop;

  assign drive_mode = cpc_pkg::cpc_drives_strobe(cfg.mode);
  assign half = cfg.osc_slow ? 5'(cpc_pkg::OSC_SLOW_HALF) :
                               5'(cpc_pkg::OSC_FAST_HALF);
  assign div_end = (div_q == half - 5'h01);

  // Rising strobe waits while the buffer is full
  always_ff @(posedge clk_sys) begin
    if (!rst_n || state_q != cpc_pkg::ST_LOAD || !drive_mode)
    begin
      div_q <= '0;
      strobe_out <= 1'b0;
    end else if (div_end)
    begin
      if (strobe_out || !v1_q)
      begin
        strobe_out <= !strobe_out;
        div_q <= '0;
      end
    end else
      div_q <= div_q + 5'h01;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n)
      strobe_oe <= 1'b0;
    else
      strobe_oe <= (state_q == cpc_pkg::ST_LOAD) && drive_mode;
  end

  // Own strobe: byte taken as the strobe rises. Far strobe: on its edge.
  assign push_req = (state_q == cpc_pkg::ST_LOAD) &&
    (drive_mode ? (div_end && !strobe_out && !v1_q)
                : (strobe_s && !strobe_prev_q));
  assign push = push_req && !v1_q;
  assign pop = v0_q && byte_ready;

  // ==========================================================
  // Two-entry byte buffer
  always_ff @(posedge clk_sys) begin
    if (!rst_n || state_q == cpc_pkg::ST_CLEAR)
    begin
      v0_q <= 1'b0;
      v1_q <= 1'b0;
      d0_q <= '0;
      d1_q <= '0;
    end else if (pop)
    begin
      if (v1_q)
      begin
        d0_q <= d1_q;
        v1_q <= push;
        if (push)
          d1_q <= data_s;
      end else
      begin
        v0_q <= push;
        if (push)
          d0_q <= data_s;
      end
    end else if (push)
    begin
      if (!v0_q)
      begin
        d0_q <= data_s;
        v0_q <= 1'b1;
      end else
      begin
        d1_q <= data_s;
        v1_q <= 1'b1;
      end
    end
  end

  assign byte_data = d0_q;
  assign byte_valid = v0_q;

  // Only a far strobe can outrun the buffer; sticky until restart
  always_ff @(posedge clk_sys) begin
    if (!rst_n || state_q == cpc_pkg::ST_CLEAR)
      overflow <= 1'b0;
    else if (push_req && v1_q)
      overflow <= 1'b1;
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  chk_io_hiz_cfg: assert property (
    in_cfg |=> (io_enable == '0) && (io_pullup == '1))
    else $error("user I/O enabled during configuration");
  chk_unused_pullup: assert property (
    !in_cfg |=> (io_pullup == ~$past(io_used)) &&
                ((io_enable & ~$past(io_used)) == '0))
    else $error("unused I/O not parked");
  chk_reset_restart: assert property (
    in_cfg && !reset_s |=> state_q == cpc_pkg::ST_CLEAR)
    else $error("reset pin did not restart configuration");
  chk_logic_reset: assert property (
    !in_cfg && opt.reset_as_logic && !reset_s |=> logic_reset)
    else $error("reset pin not routed to logic");
  chk_strobe_drive: assert property (
    state_q == cpc_pkg::ST_LOAD && drive_mode |=> strobe_oe)
    else $error("strobe not driven in own-clock mode");
  chk_done_hold: assert property (
    state_q == cpc_pkg::ST_DONE_HOLD && !done_s && reprog_s && reset_s
    |=> state_q == cpc_pkg::ST_DONE_HOLD)
    else $error("start-up while completion pin held low");
  chk_done_release: assert property (
    $rose(state_q == cpc_pkg::ST_DONE_HOLD) |=> !done_oe)
    else $error("completion pin not released");
  chk_reprog: assert property (
    !reprog_s |=> state_q == cpc_pkg::ST_CLEAR && jtag_reset)
    else $error("reprogram ignored");
  chk_gts_cfg: assert property (
    state_q == cpc_pkg::ST_LOAD && !rdtrig_s |=> global_tristate)
    else $error("global tristate missing during load");
  chk_readback_pulse: assert property (
    !in_cfg && opt.rb_enable && rb_fall && reprog_s
    |=> readback_start ##1 !readback_start)
    else $error("readback start not a single pulse");
  chk_speed_capture: assert property (
    state_q == cpc_pkg::ST_WAIT && init_rise && reprog_s && reset_s
    |=> cfg.osc_slow == $past(osc_s))
    else $error("speed select not captured");
  chk_busy_flags: assert property (
    (cfg_busy_high_flag != cfg_busy_low_flag) &&
    (cfg_busy_high_flag == $past(in_cfg)))
    else $error("busy flags disagree");

endmodule : cpc_config_pin_control
`default_nettype wire

// >>> cpc_cfg_source.sv
`timescale 1ns/10ps
`default_nettype none

// ==========
// Configuration source
module cpc_cfg_source (
  // Pin wires
  input wire logic strobe_w,
  input wire logic own_strobe,
  output logic strobe_drv,
  output logic [7:0] data
);
  int k;

  initial
  begin
    k = 0;
    strobe_drv = 1'b0;
    data = 8'h3c;
  end

  // Next byte only once the device strobe has taken this one
  always @(posedge strobe_w)
  begin
    if (own_strobe)
    begin
      k++;
      data <= 8'h3c + 8'(k);
    end
  end

  task automatic rewind();
    k = 0;
    data = 8'h3c;
  endtask : rewind

  // Strobe stands still outside the frame; odd phase to the clock
  task automatic send(input int n);
    #7;
    for (int i = 0; i < n; i++)
    begin
      data = 8'h3c + 8'(i);
      #100 strobe_drv = 1'b1;
      #100 strobe_drv = 1'b0;
    end
    data = ~data;
  endtask : send
endmodule : cpc_cfg_source
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  // ==========
  // Stimulus and wires
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic reset_pin_n = 1'b1;
  logic reprogram_n = 1'b1;
  logic [2:0] cfg_mode_sel = 3'h4;
  logic osc_speed_sel = 1'b0;
  logic rd_trig_n = 1'b1;
  logic tdo_sel = 1'b0;
  logic jtag_tdo = 1'b0;
  logic rb_serial = 1'b0;
  cpc_pkg::cpc_opt_t opt = '0;
  logic load_complete = 1'b0;
  logic byte_ready = 1'b0;
  logic own_strobe = 1'b0;
  logic init_low = 1'b0;
  logic done_low = 1'b0;
  logic own;
  logic [7:0] io_used = 8'h5a;
  logic init_out, init_oe, done_out, done_oe, strobe_out, strobe_oe;
  logic shared_out, byte_valid, overflow, cfg_busy_high_flag;
  logic cfg_busy_low_flag, mode_pullup_en, osc_user_io, logic_reset;
  logic jtag_reset, global_tristate, readback_start, done_group_apply;
  logic io_group_apply, strobe_drv;
  logic [7:0] data_in, byte_data, io_enable, io_pullup;
  logic [15:0] readback_frame;
  cpc_pkg::cpc_cfg_t cfg;
  wire logic init_w;
  wire logic done_w;
  wire logic strobe_w;
  // Enum order values of the mode table
  logic [2:0] mt [8] = '{3'h0, 3'h0, 3'h1, 3'h3, 3'h2, 3'h2, 3'h4, 3'h2};
  int err_count = 0;
  int cmp_count = 0;
  int n_done = 0;
  int n_io = 0;
  int n_rb = 0;

  // Open drain with pull-up; strobe wire driven by device or source
  assign init_w = ~(init_oe | init_low);
  assign done_w = ~(done_oe | done_low);
  assign strobe_w = strobe_oe ? strobe_out : strobe_drv;

  always #12.5 clk_sys = ~clk_sys;

  // Pulses are counted so their exact cycle does not matter
  always @(posedge clk_sys)
  begin
    if (done_group_apply === 1'b1) n_done++;
    if (io_group_apply === 1'b1) n_io++;
    if (readback_start === 1'b1) n_rb++;
  end

  cpc_cfg_source cpc_cfg_source_i (
    .strobe_w, .own_strobe, .strobe_drv, .data(data_in)
  );

  cpc_config_pin_control cpc_config_pin_control_i (
    .clk_sys, .rst_n, .reset_pin_n, .reprogram_n, .cfg_mode_sel,
    .osc_speed_sel, .rd_trig_n, .init_in(init_w), .init_out, .init_oe,
    .done_in(done_w), .done_out, .done_oe, .strobe_in(strobe_w),
    .strobe_out, .strobe_oe, .data_in, .tdo_sel, .jtag_tdo, .rb_serial,
    .shared_out, .opt, .load_complete, .io_used, .io_enable, .io_pullup,
    .byte_data, .byte_valid, .byte_ready, .overflow, .cfg,
    .cfg_busy_high_flag, .cfg_busy_low_flag, .mode_pullup_en,
    .osc_user_io, .logic_reset, .jtag_reset, .global_tristate,
    .readback_start, .readback_frame, .done_group_apply, .io_group_apply
  );

  // ==========
  // Tasks
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : settle

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  task automatic restart(input logic [2:0] sel);
    @(posedge clk_sys);
    reprogram_n <= 1'b0;
    cfg_mode_sel <= sel;
    osc_speed_sel <= sel[0];
    init_low <= 1'b1;
    settle(5);
    check("jtag_reset", jtag_reset, 1'b1);
    check("busy_high", cfg_busy_high_flag, 1'b1);
    check("init_oe", init_oe, 1'b1);
    @(posedge clk_sys);
    reprogram_n <= 1'b1;
    cpc_cfg_source_i.rewind();
    for (int n = 0; n < 600 && init_oe !== 1'b0; n++)
      settle(0);
    settle(10);
    @(posedge clk_sys);
    init_low <= 1'b0;
    settle(8);
  endtask : restart

  task automatic pop(input logic [7:0] exp);
    for (int n = 0; n < 200 && byte_valid !== 1'b1; n++)
      settle(0);
    check("byte_data", byte_data, exp);
    @(posedge clk_sys);
    byte_ready <= 1'b1;
    @(posedge clk_sys);
    byte_ready <= 1'b0;
    settle(0);
  endtask : pop

  initial
  begin
    #2_000_000;
    err_count++;
    end_sim();
  end

  // ==========
  // Tests
  initial
  begin
    settle(11);
    check("init_oe", init_oe, 1'b1);
    check("done_oe", done_oe, 1'b1);
    check("busy_low", cfg_busy_low_flag, 1'b0);
    check("mode_pull", mode_pullup_en, 1'b1);
    check("io_enable", io_enable, 8'h00);
    check("io_pullup", io_pullup, 8'hff);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    $display("test reset done");
    for (int s = 0; s < 8; s++)
    begin
      own = mt[s] inside {3'h0, 3'h1, 3'h4};
      own_strobe = own;
      restart(3'(s));
      check("mode", cfg.mode, mt[s]);
      check("osc_slow", cfg.osc_slow, s[0]);
      check("strobe_oe", strobe_oe, own);
      if (own)
      begin
        pop(8'h3c);
        pop(8'h3d);
      end
    end
    $display("test modes done");
    restart(3'h4);
    @(posedge clk_sys);
    rd_trig_n <= 1'b0;
    settle(5);
    check("gts", global_tristate, 1'b1);
    check("io_enable", io_enable, 8'h00);
    @(posedge clk_sys);
    rd_trig_n <= 1'b1;
    cpc_cfg_source_i.send(3);
    settle(6);
    check("overflow", overflow, 1'b1);
    pop(8'h3c);
    pop(8'h3d);
    settle(4);
    check("byte_valid", byte_valid, 1'b0);
    @(posedge clk_sys);
    reset_pin_n <= 1'b0;
    settle(5);
    check("init_oe", init_oe, 1'b1);
    @(posedge clk_sys);
    reset_pin_n <= 1'b1;
    restart(3'h4);
    cpc_cfg_source_i.send(1);
    pop(8'h3c);
    $display("test slave load done");
    @(posedge clk_sys);
    done_low <= 1'b1;
    load_complete <= 1'b1;
    settle(25);
    check("done_oe", done_oe, 1'b0);
    check("done_pulses", 16'(n_done), 16'h1);
    check("busy_high", cfg_busy_high_flag, 1'b1);
    check("io_enable", io_enable, 8'h00);
    check("io_pulses", 16'(n_io), 16'h0);
    @(posedge clk_sys);
    done_low <= 1'b0;
    settle(6);
    check("done_wire", done_w, 1'b1);
    check("io_pulses", 16'(n_io), 16'h1);
    check("busy_high", cfg_busy_high_flag, 1'b0);
    check("busy_low", cfg_busy_low_flag, 1'b1);
    check("io_enable", io_enable, io_used);
    check("io_pullup", io_pullup, 8'(~io_used));
    check("mode_pull", mode_pullup_en, 1'b0);
    check("osc_user", osc_user_io, 1'b1);
    $display("test completion done");
    @(posedge clk_sys);
    opt <= '{rb_enable: 1'b1, reset_as_logic: 1'b1};
    reset_pin_n <= 1'b0;
    settle(5);
    check("logic_reset", logic_reset, 1'b1);
    check("busy_high", cfg_busy_high_flag, 1'b0);
    @(posedge clk_sys);
    reset_pin_n <= 1'b1;
    rd_trig_n <= 1'b0;
    settle(5);
    check("rb_pulses", 16'(n_rb), 16'h1);
    check("rb_frame", readback_frame, 16'h0);
    check("gts", global_tristate, 1'b0);
    check("logic_reset", logic_reset, 1'b0);
    @(posedge clk_sys);
    rd_trig_n <= 1'b1;
    opt.rb_enable <= 1'b0;
    settle(3);
    @(posedge clk_sys);
    rd_trig_n <= 1'b0;
    settle(5);
    check("gts", global_tristate, 1'b1);
    check("io_enable", io_enable, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_sys);
      tdo_sel <= i[1];
      jtag_tdo <= i[0];
      rb_serial <= ~i[0];
      settle(2);
      check("shared_out", shared_out, i[1] ? i[0] : !i[0]);
    end
    $display("test user mode done");
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
